// >>> logic/timer_irq_enable.sv
`timescale 1ns/100ps

// Operation
// RULE1 - Each of the six channels has its own enable register governing only its requests.
// RULE2 - Enable bit 7 lets a register A capture or match issue a converter start request.
// RULE3 - Enable bit 6 is reserved, reads as one and ignores writes.
// RULE4 - On channels 1, 2, 4, 5 bit 5 gates the underflow flag onto its request.
// RULE5 - On channels 0 and 3 bit 5 reads as zero and ignores writes.
// RULE6 - Bit 4 gates the overflow flag onto its request on every channel.
// RULE7 - On channels 0 and 3 bit 3 gates the register D flag onto its request.
// RULE8 - On channels 1, 2, 4, 5 bit 3 reads as zero and ignores writes.
// RULE9 - On channels 0 and 3 bit 2 gates the register C flag onto its request.
// RULE10 - On channels 1, 2, 4, 5 bit 2 reads as zero and ignores writes.
// RULE11 - Bit 1 gates the register B flag onto its request on every channel.
// RULE12 - Bit 0 gates the register A flag onto its request on every channel.
// RULE13 - Overflow sets on a wrap from all ones to zero, underflow on the reverse wrap in phase mode.
// RULE14 - A flag clears when zero is written after it was read as one; writing one keeps it.
// RULE15 - Software reads a flag back after clearing it so the request drops before it exits.
// RULE16 - Each request is its flag AND its enable and stays until either one clears.
module timer_irq_enable
  import timer_irq_pkg::*;
#(
  parameter int CH_N = 6
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  input wire logic [CH_N-1:0][CNT_W-1:0] channel_counter_i,
  input wire logic [CH_N-1:0] phase_mode_i,
  input wire logic [CH_N-1:0] rega_evt_i,
  input wire logic [CH_N-1:0] regb_evt_i,
  input wire logic [CH_N-1:0] regc_evt_i,
  input wire logic [CH_N-1:0] regd_evt_i,
  output logic [CH_N-1:0] rega_irq_req_o,
  output logic [CH_N-1:0] regb_irq_req_o,
  output logic [CH_N-1:0] regc_irq_req_o,
  output logic [CH_N-1:0] regd_irq_req_o,
  output logic [CH_N-1:0] overflow_irq_req_o,
  output logic [CH_N-1:0] underflow_irq_req_o,
  output logic [CH_N-1:0] conv_start_o,
  output logic conv_irq_o
);

  if (CH_N < 1 || CH_N > DATA_W) begin : g_bad_ch
    $error("CH_N must lie between 1 and the data width");
  end

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [CH_N-1:0][7:0] en;
    logic [CH_N-1:0][FLAG_W-1:0] flg;
    logic [CH_N-1:0][FLAG_W-1:0] armed;
    logic [CH_N-1:0][CNT_W-1:0] cnt_prev;
    logic prev_ok;
    logic [CH_N-1:0] trig;
    logic [CH_N-1:0] cst;
    logic [CH_N-1:0] cmask;
    logic [DATA_W-1:0] rdata;
  } state_t;

  state_t s_q;
  state_t s_d;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic [FLAG_W-1:0] setv;
    logic [FLAG_W-1:0] clrv;
    logic [FLAG_W-1:0] fmask;
    logic [7:0] emask;
    logic wr_en;
    logic wr_st;
    logic rd_en;
    logic rd_st;
    setv = '0;
    clrv = '0;
    fmask = '0;
    emask = '0;
    wr_en = 1'b0;
    wr_st = 1'b0;
    rd_en = 1'b0;
    rd_st = 1'b0;
    s_d = s_q;
    s_d.rdata = '0;
    s_d.prev_ok = 1'b1;
    for (int c = 0; c < CH_N; c++) begin
      wr_en = wr_i && (addr_i == chan_addr(EN_BASE, c)); // RULE1
      wr_st = wr_i && (addr_i == chan_addr(ST_BASE, c));
      rd_en = rd_i && (addr_i == chan_addr(EN_BASE, c));
      rd_st = rd_i && (addr_i == chan_addr(ST_BASE, c));
      emask = en_mask(c);
      fmask = emask[FLAG_W-1:0];
      s_d.cnt_prev[c] = channel_counter_i[c];
      // Flag sources
      setv = '0;
      setv[BIT_A] = rega_evt_i[c];
      setv[BIT_B] = regb_evt_i[c];
      setv[BIT_C] = regc_evt_i[c];
      setv[BIT_D] = regd_evt_i[c];
      setv[BIT_OVF] = s_q.prev_ok && (s_q.cnt_prev[c] == CNT_MAX)
                      && (channel_counter_i[c] == CNT_MIN); // RULE13
      setv[BIT_UNF] = s_q.prev_ok && phase_mode_i[c]
                      && (s_q.cnt_prev[c] == CNT_MIN)
                      && (channel_counter_i[c] == CNT_MAX); // RULE13
      setv = setv & fmask;
      // Clear needs a prior read of one, then a written zero
      clrv = wr_st ? (s_q.armed[c] & ~wdata_i[FLAG_W-1:0]) : '0; // RULE14
      s_d.flg[c] = setv | (s_q.flg[c] & ~clrv); // RULE14
      if (wr_st) begin
        s_d.armed[c] = '0;
      end
      if (rd_st) begin
        s_d.armed[c] = s_q.flg[c];
        s_d.rdata = ST_FIXED | {2'b00, s_q.flg[c]};
      end
      // Reserved bits never store
      if (wr_en) begin
        s_d.en[c] = wdata_i & en_mask(c); // RULE3 RULE5 RULE8 RULE10
      end
      if (rd_en) begin
        s_d.rdata = s_q.en[c] | EN_FIXED; // RULE3
      end
      s_d.trig[c] = rega_evt_i[c] && s_q.en[c][BIT_TRIG]; // RULE2
    end
    // Converter start events: sticky, write one to clear
    s_d.cst = s_d.trig | (s_q.cst & ~((wr_i && addr_i == CST_ADDR) ?
              wdata_i[CH_N-1:0] : '0));
    if (wr_i && addr_i == CMASK_ADDR) begin
      s_d.cmask = wdata_i[CH_N-1:0];
    end
    if (rd_i && addr_i == CST_ADDR) begin
      s_d.rdata = DATA_W'(s_q.cst);
    end
    if (rd_i && addr_i == CMASK_ADDR) begin
      s_d.rdata = DATA_W'(s_q.cmask);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q.en <= {CH_N{EN_RST}};
      s_q.flg <= {CH_N{FLG_RST}};
      s_q.armed <= {CH_N{FLG_RST}};
      s_q.cnt_prev <= {CH_N{CNT_MIN}};
      s_q.prev_ok <= 1'b0;
      s_q.trig <= '0;
      s_q.cst <= '0;
      s_q.cmask <= '0;
      s_q.rdata <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  always_comb begin
    for (int c = 0; c < CH_N; c++) begin
      rega_irq_req_o[c] = s_q.flg[c][BIT_A] & s_q.en[c][BIT_A]; // RULE12 RULE16
      regb_irq_req_o[c] = s_q.flg[c][BIT_B] & s_q.en[c][BIT_B]; // RULE11 RULE16
      regc_irq_req_o[c] = s_q.flg[c][BIT_C] & s_q.en[c][BIT_C]; // RULE9 RULE16
      regd_irq_req_o[c] = s_q.flg[c][BIT_D] & s_q.en[c][BIT_D]; // RULE7 RULE16
      overflow_irq_req_o[c] = s_q.flg[c][BIT_OVF] & s_q.en[c][BIT_OVF]; // RULE6 RULE16
      underflow_irq_req_o[c] = s_q.flg[c][BIT_UNF] & s_q.en[c][BIT_UNF]; // RULE4 RULE16
    end
  end

  assign conv_start_o = s_q.trig;
  assign conv_irq_o = |(s_q.cst & s_q.cmask);
  assign rdata_o = s_q.rdata;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  for (genvar c = 0; c < CH_N; c++) begin : g_chk
    localparam logic [7:0] EA = chan_addr(EN_BASE, c);
    localparam logic [7:0] SA = chan_addr(ST_BASE, c);

    a_chan_isolation: // RULE1
    assert property (!(wr_i && addr_i == EA) |=> $stable(s_q.en[c]))
      else $error("enable changed by another address");

    a_conv_trig_gate: // RULE2
    assert property (rega_evt_i[c] |=> conv_start_o[c] == $past(s_q.en[c][BIT_TRIG]))
      else $error("converter start not gated by its enable");

    a_rsvd_six_one: // RULE3
    assert property (rd_i && addr_i == EA |=> rdata_o[BIT_RSV])
      else $error("reserved enable bit read as zero");

    a_unf_req_on: // RULE4
    assert property (underflow_irq_req_o[c] |-> !has_cd(c) && s_q.en[c][BIT_UNF])
      else $error("underflow request without enable");

    a_unf_rsvd_zero: // RULE5
    assert property (has_cd(c) && rd_i && addr_i == EA |=> !rdata_o[BIT_UNF])
      else $error("reserved underflow enable read as one");

    a_ovf_req_on: // RULE6
    assert property (wr_i && addr_i == EA && wdata_i[BIT_OVF] && s_q.flg[c][BIT_OVF]
                     |=> overflow_irq_req_o[c])
      else $error("overflow request missing after enable");

    a_regd_req_on: // RULE7
    assert property (regd_evt_i[c] && s_q.en[c][BIT_D] && !wr_i |=> regd_irq_req_o[c]
                     == has_cd(c))
      else $error("register D request wrong");

    a_cd_rsvd_zero: // RULE8 RULE10
    assert property (!has_cd(c) && rd_i && addr_i == EA |=> rdata_o[BIT_D:BIT_C] == 2'b00)
      else $error("reserved C or D enable read as one");

    a_regc_req_on: // RULE9
    assert property (regc_evt_i[c] && s_q.en[c][BIT_C] && !wr_i |=> regc_irq_req_o[c]
                     == has_cd(c))
      else $error("register C request wrong");

    a_regb_req_on: // RULE11
    assert property (regb_evt_i[c] && s_q.en[c][BIT_B] && !wr_i |=> regb_irq_req_o[c])
      else $error("register B request missing");

    a_rega_req_off: // RULE12
    assert property (!s_q.en[c][BIT_A] && !wr_i |=> !rega_irq_req_o[c])
      else $error("register A request while disabled");

    a_ovf_wrap_set: // RULE13
    assert property (s_q.prev_ok && s_q.cnt_prev[c] == CNT_MAX
                     && channel_counter_i[c] == CNT_MIN |=> s_q.flg[c][BIT_OVF])
      else $error("overflow flag not set on wrap");

    a_flag_clear: // RULE14
    assert property (rd_i && addr_i == SA && s_q.flg[c][BIT_A] ##1
                     wr_i && addr_i == SA && !wdata_i[BIT_A] && !rega_evt_i[c]
                     |=> !s_q.flg[c][BIT_A])
      else $error("flag not cleared by read one then write zero");

    a_req_hold: // RULE16
    assert property (rega_irq_req_o[c] && !wr_i |=> rega_irq_req_o[c])
      else $error("request dropped with no write");

    // ------------------------------------------------------------
    // Gating, reserved storage, flag set and clear, and hold checks
    // ------------------------------------------------------------
    a_conv_trig_off: // RULE2
    assert property (!s_q.en[c][BIT_TRIG] |=> !conv_start_o[c])
      else $error("converter start while its enable is off");

    a_conv_no_evt: // RULE2
    assert property (!rega_evt_i[c] |=> !conv_start_o[c])
      else $error("converter start without a register A event");

    a_conv_status_set: // RULE2
    assert property (conv_start_o[c] |-> s_q.cst[c])
      else $error("converter start not recorded in its status");

    a_rsvd_six_store: // RULE3
    assert property (!s_q.en[c][BIT_RSV])
      else $error("reserved enable bit stored a write");

    a_unf_req_off: // RULE4
    assert property (!s_q.en[c][BIT_UNF] && !wr_i |=> !underflow_irq_req_o[c])
      else $error("underflow request while disabled");

    a_unf_wrap_req: // RULE4
    assert property (s_q.prev_ok && phase_mode_i[c] && s_q.cnt_prev[c] == CNT_MIN
                     && channel_counter_i[c] == CNT_MAX && s_q.en[c][BIT_UNF] && !wr_i
                     |=> underflow_irq_req_o[c])
      else $error("underflow request missing after wrap");

    a_unf_rsvd_store: // RULE5
    assert property (has_cd(c) |-> !s_q.en[c][BIT_UNF] && !s_q.flg[c][BIT_UNF])
      else $error("reserved underflow bit stored a value");

    a_ovf_req_off: // RULE6
    assert property (!s_q.en[c][BIT_OVF] && !wr_i |=> !overflow_irq_req_o[c])
      else $error("overflow request while disabled");

    a_regd_req_off: // RULE7
    assert property (!s_q.en[c][BIT_D] && !wr_i |=> !regd_irq_req_o[c])
      else $error("register D request while disabled");

    a_cd_rsvd_store: // RULE8 RULE10
    assert property (!has_cd(c) |-> s_q.en[c][BIT_D:BIT_C] == 2'h0
                     && s_q.flg[c][BIT_D:BIT_C] == 2'h0)
      else $error("reserved C or D bit stored a value");

    a_regc_req_off: // RULE9
    assert property (!s_q.en[c][BIT_C] && !wr_i |=> !regc_irq_req_o[c])
      else $error("register C request while disabled");

    a_regb_req_off: // RULE11
    assert property (!s_q.en[c][BIT_B] && !wr_i |=> !regb_irq_req_o[c])
      else $error("register B request while disabled");

    a_rega_req_on: // RULE12
    assert property (rega_evt_i[c] && s_q.en[c][BIT_A] && !wr_i |=> rega_irq_req_o[c])
      else $error("register A request missing");

    a_unf_wrap_set: // RULE13
    assert property (!has_cd(c) && s_q.prev_ok && phase_mode_i[c]
                     && s_q.cnt_prev[c] == CNT_MIN && channel_counter_i[c] == CNT_MAX
                     |=> s_q.flg[c][BIT_UNF])
      else $error("underflow flag not set on wrap");

    a_ovf_no_cause: // RULE13
    assert property (!s_q.flg[c][BIT_OVF] && !(s_q.prev_ok && s_q.cnt_prev[c] == CNT_MAX
                     && channel_counter_i[c] == CNT_MIN) |=> !s_q.flg[c][BIT_OVF])
      else $error("overflow flag set without a wrap");

    a_unf_no_phase: // RULE13
    assert property (!phase_mode_i[c] && !s_q.flg[c][BIT_UNF] |=> !s_q.flg[c][BIT_UNF])
      else $error("underflow flag set outside phase mode");

    a_flag_keep_one: // RULE14
    assert property (wr_i && addr_i == SA && wdata_i[BIT_A] && s_q.flg[c][BIT_A]
                     |=> s_q.flg[c][BIT_A])
      else $error("flag cleared by a written one");

    a_flag_unread_keep: // RULE14
    assert property (!s_q.armed[c][BIT_B] && s_q.flg[c][BIT_B] |=> s_q.flg[c][BIT_B])
      else $error("flag cleared without a prior read");

    a_flags_no_stray: // RULE1 RULE14
    assert property (!(wr_i && addr_i == SA)
                     |=> (s_q.flg[c] & $past(s_q.flg[c])) == $past(s_q.flg[c]))
      else $error("flag cleared with no write to its status");

    a_req_drop_en: // RULE16
    assert property (wr_i && addr_i == EA && !wdata_i[BIT_B] |=> !regb_irq_req_o[c])
      else $error("request kept after its enable cleared");

    a_ovf_req_hold: // RULE16
    assert property (overflow_irq_req_o[c] && !wr_i |=> overflow_irq_req_o[c])
      else $error("overflow request dropped with no write");

    a_unf_req_hold: // RULE16
    assert property (underflow_irq_req_o[c] && !wr_i |=> underflow_irq_req_o[c])
      else $error("underflow request dropped with no write");

    a_regd_req_hold: // RULE16
    assert property (regd_irq_req_o[c] && !wr_i |=> regd_irq_req_o[c])
      else $error("register D request dropped with no write");
  end

endmodule

// >>> logic/timer_irq_pkg.sv
package timer_irq_pkg;

  // ------------------------------------------------------------
  // Bus and register map
  // ------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int FLAG_W = 6;
  localparam int CNT_W = 16;
  localparam logic [7:0] EN_BASE = 8'h00;
  localparam logic [7:0] ST_BASE = 8'h20;
  localparam logic [7:0] CST_ADDR = 8'h40;
  localparam logic [7:0] CMASK_ADDR = 8'h44;
  localparam logic [7:0] REG_STRIDE = 8'h04;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int BIT_TRIG = 7;
  localparam int BIT_RSV = 6;
  localparam int BIT_UNF = 5;
  localparam int BIT_OVF = 4;
  localparam int BIT_D = 3;
  localparam int BIT_C = 2;
  localparam int BIT_B = 1;
  localparam int BIT_A = 0;

  // ------------------------------------------------------------
  // Masks and fixed values
  // ------------------------------------------------------------
  localparam logic [7:0] EN_RST = 8'h00;
  localparam logic [7:0] EN_FIXED = 8'h40;
  localparam logic [7:0] ST_FIXED = 8'hC0;
  localparam logic [7:0] EN_ALL = 8'h93;
  localparam logic [7:0] EN_UNF = 8'h20;
  localparam logic [7:0] EN_CD = 8'h0C;
  localparam logic [5:0] FLG_RST = 6'h00;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_MIN = 16'h0000;

  // Channels 0 and 3 carry registers C and D; the others underflow
  function automatic logic has_cd(input int ch);
    return (ch % 3) == 0;
  endfunction

  function automatic logic [7:0] en_mask(input int ch);
    return has_cd(ch) ? (EN_ALL | EN_CD) : (EN_ALL | EN_UNF);
  endfunction

  function automatic logic [7:0] chan_addr(input logic [7:0] base, input int ch);
    return base + 8'(ch) * REG_STRIDE;
  endfunction

endpackage

// >>> tb/conv_sink.sv
`timescale 1ns/100ps

// ------------------------------------------------------------
// Converter trigger input: tallies start requests
// ------------------------------------------------------------
module conv_sink #(
  parameter int CH_N = 6
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [CH_N-1:0] conv_start_i,
  output int starts_o
);
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      starts_o <= 0;
    end else begin
      starts_o <= starts_o + $countones(conv_start_i);
    end
  end
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/100ps

module tb_top;
  import timer_irq_pkg::*;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [5:0][15:0] cnt = '0;
  logic [5:0] phase = '0;
  logic [5:0] ea = '0, eb = '0, ec = '0, ed = '0;
  logic [7:0] rdata;
  logic [5:0] ra, rb, rc, rdq, ro, ru, cs;
  logic cirq;
  int starts;
  int num_errors = 0;
  int compares = 0;

  always #5 clk_i = ~clk_i;

  timer_irq_enable #(.CH_N(6)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .channel_counter_i(cnt),
    .phase_mode_i(phase), .rega_evt_i(ea), .regb_evt_i(eb), .regc_evt_i(ec),
    .regd_evt_i(ed), .rega_irq_req_o(ra), .regb_irq_req_o(rb), .regc_irq_req_o(rc),
    .regd_irq_req_o(rdq), .overflow_irq_req_o(ro), .underflow_irq_req_o(ru),
    .conv_start_o(cs), .conv_irq_o(cirq));

  conv_sink #(.CH_N(6)) sink (.clk_i(clk_i), .rst_b_i(rst_b_i), .conv_start_i(cs),
    .starts_o(starts));

  // ------------------------------------------------------------
  // Access and compare tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic pulse_all();
    @(posedge clk_i);
    {ea, eb, ec, ed} <= '1;
    @(posedge clk_i);
    {ea, eb, ec, ed} <= '0;
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  task automatic test_done();
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    #50us;
    num_errors++;
    test_done();
  end

  initial begin
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    for (int n = 0; n < 6; n++) begin
      rd_reg(EN_BASE + 8'(4 * n), 8'h40);
      rd_reg(ST_BASE + 8'(4 * n), 8'hC0);
      wr_reg(EN_BASE + 8'(4 * n), 8'hFF);
      rd_reg(EN_BASE + 8'(4 * n), (n % 3 == 0) ? 8'hDF : 8'hF3);
    end
    pulse_all();
    @(posedge clk_i);
    cnt <= {6{16'hFFFF}};
    @(posedge clk_i);
    cnt <= '0;
    @(posedge clk_i);
    phase <= '1;
    @(posedge clk_i);
    cnt <= {6{16'hFFFF}};
    repeat (3) @(posedge clk_i);
    #1;
    chk(8'(ra), 8'h3F);
    chk(8'(rb), 8'h3F);
    chk(8'(rc), 8'h09);
    chk(8'(rdq), 8'h09);
    chk(8'(ro), 8'h3F);
    chk(8'(ru), 8'h36);
    chk(8'(starts), 8'h06);
    rd_reg(ST_BASE + 8'h04, 8'hF3);
    rd_reg(CST_ADDR, 8'h3F);
    wr_reg(CMASK_ADDR, 8'h3F);
    @(posedge clk_i);
    #1;
    chk(8'(cirq), 8'h01);
    wr_reg(CST_ADDR, 8'h3F);
    @(posedge clk_i);
    #1;
    chk(8'(cirq), 8'h00);
    rd_reg(ST_BASE, 8'hDF);
    wr_reg(ST_BASE, 8'hDE);
    rd_reg(ST_BASE, 8'hDE);
    chk(8'(ra), 8'h3E);
    wr_reg(EN_BASE + 8'h04, 8'h00);
    @(posedge clk_i);
    #1;
    chk(8'(rb), 8'h3D);
    for (int n = 0; n < 6; n++) begin
      wr_reg(EN_BASE + 8'(4 * n), 8'h00);
    end
    pulse_all();
    chk(8'(ra | rb | rc | rdq | ro | ru), 8'h00);
    chk(8'(starts), 8'h06);
    rd_reg(EN_BASE + 8'h0C, 8'h40);
    rd_reg(8'h80, 8'h00);
    test_done();
  end
endmodule
